// ---- include/ircmt_params.svh ----
// constants and contract list for the infrared carrier modulation timer
// Contract
// R1: timer runs only while the run-enable bit is 1, idle otherwise.
// R2: one dedicated infrared output pin and one dedicated infrared input pin.
// R3: with run-enable 0, pin level and drive follow the manual bits.
// R4: carrier high time from upper byte, low time from lower byte.
// R5: data bit and modulation time select carrier or idle level.
// R6: transmit start loads counter from modulation time, then counts down.
// R7: receive makes the counter count up from its current value.
// R8: a config bit selects clear-on-capture or free running in receive.
// R9: counter wrap from maximum to zero sets the overflow flag.
// R10: overflow interrupts the CPU only when interrupt-enable is 1.
// R11: timer clock is system clock over 2^divider; carrier times are byte+1.
// R12: at zero, next carrier clock reloads, resamples, sets flag, interrupts.
// R13: data 1 sends carrier (inverted by polarity); data 0 sends idle level.
// R14: each qualified receive edge copies pin level and counter value.
// R15: the overflow flag stays set until software clears it.
`ifndef IRCMT_PARAMS_SVH
`define IRCMT_PARAMS_SVH
`define IRCMT_ADDR_W 3
`define IRCMT_OFS_CTRL 3'h0
`define IRCMT_OFS_CARRIER 3'h1
`define IRCMT_OFS_MODTIME 3'h2
`define IRCMT_OFS_VALUE 3'h3
`define IRCMT_OFS_STATUS 3'h4
`define IRCMT_OFS_MASK 3'h5
`define IRCMT_OFS_POWER 3'h6
`define IRCMT_CTRL_EN 0
`define IRCMT_CTRL_TX 1
`define IRCMT_CTRL_DATA 2
`define IRCMT_CTRL_POL 3
`define IRCMT_CTRL_RELOAD 4
`define IRCMT_CTRL_RXSEL 5
`define IRCMT_CTRL_DIV 7
`define IRCMT_CTRL_CFME 10
`define IRCMT_PWR_OUT 0
`define IRCMT_PWR_OE 1
`define IRCMT_ST_IF 0
`define IRCMT_ST_OV 1
`define IRCMT_RST_16 16'h0000
`define IRCMT_CNT_MAX 16'hFFFF
`endif

// ---- include/ircmt_pkg.sv ----
// types for the infrared carrier modulation timer
package ircmt_pkg;
  typedef enum logic [2:0] {
    IRCMT_IDLE = 3'b001,
    IRCMT_TX = 3'b010,
    IRCMT_RX = 3'b100
  } ircmt_state_type;
  typedef logic [15:0] ircmt_word_type;
endpackage : ircmt_pkg

// ---- hdl/ircmt_clkdiv.sv ----
// timer clock enable divider: one pulse every 2^div system clocks
`timescale 1ns/10ps
`default_nettype none
module ircmt_clkdiv
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_run,
  input wire logic [2:0] i_div,
  output logic o_tick
);
  logic [6:0] cnt_r;
  logic [6:0] lim;

  // limit is 2^div minus one; div 0 gives a pulse every cycle
  assign lim = 7'((8'h01 << i_div) - 8'h01);

  // counter restarts whenever the timer is stopped
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_r <= 7'h00;
      o_tick <= 1'b0;
    end
    else if (!i_run)
    begin
      cnt_r <= 7'h00;
      o_tick <= 1'b0;
    end
    else if (cnt_r >= lim)
    begin
      cnt_r <= 7'h00;
      o_tick <= 1'b1; // R11
    end
    else
    begin
      cnt_r <= cnt_r + 7'h01;
      o_tick <= 1'b0;
    end
  end
endmodule : ircmt_clkdiv
`default_nettype wire

// ---- hdl/ircmt_top.sv ----
// infrared carrier modulation timer with avalon-mm register slave
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ircmt_params.svh"
module ircmt_top
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [`IRCMT_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  input wire logic i_infrared_in_pin,
  output logic o_infrared_out_pin,
  output logic o_infrared_out_pin_oe
);
  import ircmt_pkg::*;

  // control and data registers
  logic timer_run_enable_r;
  logic transmit_select_bit_r;
  logic modulation_data_bit_r;
  logic output_polarity_bit_r;
  logic reload_on_capture_r;
  logic [1:0] edge_select_r;
  logic [2:0] timer_clock_divider_r;
  logic clock_mode_fine_r;
  logic manual_out_level_r;
  logic manual_out_drive_enable_r;
  ircmt_word_type carrier_timing_reg_r;
  ircmt_word_type modulation_time_reg_r;
  ircmt_word_type value_counter_r;
  logic infrared_irq_flag_r;
  logic counter_overflow_flag_r;
  logic [1:0] irq_mask_r;
  ircmt_state_type state_r;
  // latched transmit settings for the current interval
  ircmt_word_type carrier_lat_r;
  logic data_lat_r;
  logic pol_lat_r;
  logic carrier_phase_r;
  logic [7:0] carrier_cnt_r;
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_prev_r;
  logic ack_r;

  logic tick;
  logic carrier_tick;
  logic cnt_clk;
  logic wr_acc;
  logic rd_acc;
  logic tx_start;
  logic tx_reload;
  logic rx_edge;
  logic rx_wrap;
  logic [31:0] rd_mux;
  logic [7:0] phase_lim;

  ircmt_clkdiv u_ircmt_clkdiv
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_run(timer_run_enable_r),
    .i_div(timer_clock_divider_r),
    .o_tick(tick)
  );

  // bus strobes; one wait state so every answer comes from a register
  assign wr_acc = i_avs_write && ack_r;
  assign rd_acc = i_avs_read && ack_r;

  // acknowledge flop: high in the second cycle of each request
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      ack_r <= 1'b0;
    else
      ack_r <= (i_avs_read || i_avs_write) && !ack_r;
  end

  always_comb
  begin
    o_avs_waitrequest = !ack_r;
  end

  // control register write
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      timer_run_enable_r <= 1'b0;
      transmit_select_bit_r <= 1'b0;
      output_polarity_bit_r <= 1'b0;
      reload_on_capture_r <= 1'b0;
      edge_select_r <= 2'h0;
      timer_clock_divider_r <= 3'h0;
      clock_mode_fine_r <= 1'b0;
      manual_out_level_r <= 1'b0;
      manual_out_drive_enable_r <= 1'b0;
      carrier_timing_reg_r <= `IRCMT_RST_16;
      irq_mask_r <= 2'h0;
    end
    else if (wr_acc && i_avs_byteenable[0])
    begin
      if (i_avs_address == `IRCMT_OFS_CTRL)
      begin
        timer_run_enable_r <= i_avs_writedata[`IRCMT_CTRL_EN];
        transmit_select_bit_r <= i_avs_writedata[`IRCMT_CTRL_TX];
        output_polarity_bit_r <= i_avs_writedata[`IRCMT_CTRL_POL];
        reload_on_capture_r <= i_avs_writedata[`IRCMT_CTRL_RELOAD];
        edge_select_r <= i_avs_writedata[`IRCMT_CTRL_RXSEL +: 2];
        timer_clock_divider_r <= i_avs_writedata[`IRCMT_CTRL_DIV +: 3];
        clock_mode_fine_r <= i_avs_writedata[`IRCMT_CTRL_CFME];
      end
      else if (i_avs_address == `IRCMT_OFS_CARRIER)
        carrier_timing_reg_r <= i_avs_writedata[15:0];
      else if (i_avs_address == `IRCMT_OFS_MASK)
        irq_mask_r <= i_avs_writedata[1:0];
      else if (i_avs_address == `IRCMT_OFS_POWER)
      begin
        manual_out_level_r <= i_avs_writedata[`IRCMT_PWR_OUT];
        manual_out_drive_enable_r <= i_avs_writedata[`IRCMT_PWR_OE];
      end
    end
  end

  // receive pin synchroniser, edge detect only on the second stage
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_s1_r <= 1'b0;
      rx_s2_r <= 1'b0;
      rx_prev_r <= 1'b0;
    end
    else
    begin
      rx_s1_r <= i_infrared_in_pin; // R2
      rx_s2_r <= rx_s1_r;
      rx_prev_r <= rx_s2_r;
    end
  end

  // edge select: 0 falling, 1 rising, 2 and 3 both
  always_comb
  begin
    rx_edge = 1'b0;
    if (state_r == IRCMT_RX)
    begin
      if (edge_select_r == 2'h0)
        rx_edge = rx_prev_r && !rx_s2_r;
      else if (edge_select_r == 2'h1)
        rx_edge = !rx_prev_r && rx_s2_r;
      else
        rx_edge = rx_prev_r ^ rx_s2_r;
    end
  end

  // state: transmit or receive only while run-enable is set
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      state_r <= IRCMT_IDLE;
    else if (!timer_run_enable_r)
      state_r <= IRCMT_IDLE; // R1
    else if (transmit_select_bit_r)
      state_r <= IRCMT_TX;
    else
      state_r <= IRCMT_RX;
  end

  // transmit begins on entry to the transmit state from either other state
  assign tx_start = timer_run_enable_r && transmit_select_bit_r && (state_r != IRCMT_TX);

  // carrier generator; a phase ends after byte+1 timer clocks
  assign phase_lim = carrier_phase_r ? carrier_lat_r[15:8] : carrier_lat_r[7:0]; // R4
  assign carrier_tick = tick && !carrier_phase_r && (carrier_cnt_r == phase_lim);
  assign cnt_clk = clock_mode_fine_r ? tick : carrier_tick;
  assign tx_reload = (state_r == IRCMT_TX) && cnt_clk && (value_counter_r == `IRCMT_RST_16);

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      carrier_phase_r <= 1'b1;
      carrier_cnt_r <= 8'h00;
    end
    else if (state_r == IRCMT_IDLE || tx_start)
    begin
      carrier_phase_r <= 1'b1;
      carrier_cnt_r <= 8'h00;
    end
    else if (tick)
    begin
      if (carrier_cnt_r == phase_lim)
      begin
        carrier_cnt_r <= 8'h00; // R11
        carrier_phase_r <= !carrier_phase_r;
      end
      else
        carrier_cnt_r <= carrier_cnt_r + 8'h01;
    end
  end

  // interval settings latched at start and at each reload
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      carrier_lat_r <= `IRCMT_RST_16;
      data_lat_r <= 1'b0;
      pol_lat_r <= 1'b0;
    end
    else if (tx_start || tx_reload || state_r != IRCMT_TX)
    begin
      carrier_lat_r <= carrier_timing_reg_r; // R12
      data_lat_r <= modulation_data_bit_r;
      pol_lat_r <= output_polarity_bit_r;
    end
  end

  // value counter: down in transmit, up in receive, writable by software
  assign rx_wrap = (state_r == IRCMT_RX) && cnt_clk && (value_counter_r == `IRCMT_CNT_MAX);

  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      value_counter_r <= `IRCMT_RST_16;
    else if (tx_start || tx_reload)
      value_counter_r <= modulation_time_reg_r; // R6 R12
    else if (state_r == IRCMT_TX && cnt_clk)
      value_counter_r <= value_counter_r - 16'h0001; // R6
    else if (rx_edge && reload_on_capture_r)
      value_counter_r <= `IRCMT_RST_16; // R8
    else if (state_r == IRCMT_RX && cnt_clk)
      value_counter_r <= value_counter_r + 16'h0001; // R7 R9
    else if (wr_acc && i_avs_address == `IRCMT_OFS_VALUE && i_avs_byteenable[0])
      value_counter_r <= i_avs_writedata[15:0];
  end

  // modulation time and data bit; capture overrides a software write
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      modulation_time_reg_r <= `IRCMT_RST_16;
      modulation_data_bit_r <= 1'b0;
    end
    else if (rx_edge)
    begin
      modulation_time_reg_r <= value_counter_r; // R14
      modulation_data_bit_r <= rx_s2_r; // R14
    end
    else if (wr_acc && i_avs_byteenable[0])
    begin
      if (i_avs_address == `IRCMT_OFS_MODTIME)
        modulation_time_reg_r <= i_avs_writedata[15:0];
      else if (i_avs_address == `IRCMT_OFS_CTRL)
        modulation_data_bit_r <= i_avs_writedata[`IRCMT_CTRL_DATA];
    end
  end

  // sticky flags: hardware set wins over write-one-to-clear
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      infrared_irq_flag_r <= 1'b0;
      counter_overflow_flag_r <= 1'b0;
    end
    else
    begin
      if (tx_reload || rx_edge)
        infrared_irq_flag_r <= 1'b1; // R12
      else if (wr_acc && i_avs_address == `IRCMT_OFS_STATUS && i_avs_writedata[`IRCMT_ST_IF])
        infrared_irq_flag_r <= 1'b0;
      if (rx_wrap)
        counter_overflow_flag_r <= 1'b1; // R9 R15
      else if (wr_acc && i_avs_address == `IRCMT_OFS_STATUS && i_avs_writedata[`IRCMT_ST_OV])
        counter_overflow_flag_r <= 1'b0; // R15
    end
  end

  // interrupt is a level from a flop, gated by the mask
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_irq <= 1'b0;
    else
      o_irq <= (infrared_irq_flag_r && irq_mask_r[`IRCMT_ST_IF]) ||
               (counter_overflow_flag_r && irq_mask_r[`IRCMT_ST_OV]); // R10
  end

  // output pin: manual bits when stopped, modulated carrier when transmitting
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_infrared_out_pin <= 1'b0;
      o_infrared_out_pin_oe <= 1'b0;
    end
    else if (!timer_run_enable_r)
    begin
      o_infrared_out_pin <= manual_out_level_r; // R3
      o_infrared_out_pin_oe <= manual_out_drive_enable_r; // R3
    end
    else
    begin
      o_infrared_out_pin_oe <= 1'b1;
      if (state_r == IRCMT_TX && data_lat_r)
        o_infrared_out_pin <= carrier_phase_r ^ pol_lat_r; // R5 R13
      else
        o_infrared_out_pin <= pol_lat_r; // R13
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (i_avs_address == `IRCMT_OFS_CTRL)
      rd_mux = {21'h000000, clock_mode_fine_r, timer_clock_divider_r, edge_select_r,
                reload_on_capture_r, output_polarity_bit_r, modulation_data_bit_r,
                transmit_select_bit_r, timer_run_enable_r};
    else if (i_avs_address == `IRCMT_OFS_CARRIER)
      rd_mux = {16'h0000, carrier_timing_reg_r};
    else if (i_avs_address == `IRCMT_OFS_MODTIME)
      rd_mux = {16'h0000, modulation_time_reg_r};
    else if (i_avs_address == `IRCMT_OFS_VALUE)
      rd_mux = {16'h0000, value_counter_r};
    else if (i_avs_address == `IRCMT_OFS_STATUS)
      rd_mux = {30'h00000000, counter_overflow_flag_r, infrared_irq_flag_r};
    else if (i_avs_address == `IRCMT_OFS_MASK)
      rd_mux = {30'h00000000, irq_mask_r};
    else if (i_avs_address == `IRCMT_OFS_POWER)
      rd_mux = {30'h00000000, manual_out_drive_enable_r, manual_out_level_r};
  end

  // read data registered in the wait cycle, stands at the acknowledging edge
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_avs_readdata <= 32'h0000_0000;
    else if (i_avs_read && !ack_r)
      o_avs_readdata <= rd_mux;
  end

  // checks
  sequence s_zero_tick;
    (state_r == IRCMT_TX) && cnt_clk && (value_counter_r == 16'h0000);
  endsequence

  a_stopped_manual: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // R3
    !timer_run_enable_r |=> o_infrared_out_pin_oe == $past(manual_out_drive_enable_r))
    else $error("manual drive not followed");
  a_idle_when_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // R1
    !timer_run_enable_r |=> state_r == IRCMT_IDLE)
    else $error("timer active while disabled");
  a_tx_reload: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // R12
    s_zero_tick |=> value_counter_r == $past(modulation_time_reg_r) && infrared_irq_flag_r)
    else $error("no reload at zero");
  a_tx_count_down: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // R6
    (state_r == IRCMT_TX) && cnt_clk && !tx_start && value_counter_r != 16'h0000
    |=> value_counter_r == $past(value_counter_r) - 16'h0001)
    else $error("transmit counter not decrementing");
  a_rx_overflow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // R9
    rx_wrap && !rx_edge |=> counter_overflow_flag_r && value_counter_r == 16'h0000)
    else $error("overflow not flagged");
  a_ovf_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // R15
    counter_overflow_flag_r && !wr_acc |=> counter_overflow_flag_r)
    else $error("overflow flag lost");
  a_irq_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // R10
    counter_overflow_flag_r && !irq_mask_r[1] && !infrared_irq_flag_r |=> !o_irq)
    else $error("interrupt while disabled");
  a_rx_capture: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // R14
    rx_edge |=> modulation_time_reg_r == $past(value_counter_r) && modulation_data_bit_r == $past(rx_s2_r))
    else $error("capture did not copy");
  a_rx_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // R8
    rx_edge && reload_on_capture_r |=> value_counter_r == 16'h0000)
    else $error("counter not cleared on capture");
  a_idle_level: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b) // R13
    timer_run_enable_r && state_r == IRCMT_TX && !data_lat_r |=> o_infrared_out_pin == $past(pol_lat_r))
    else $error("idle level wrong");
endmodule : ircmt_top
`default_nettype wire

// ---- verif/ircmt_ir_model.sv ----
// behavioural infrared emitter driver and receiver facing the timer pins
`timescale 1ns/10ps
`default_nettype none
module ircmt_ir_model
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_out_pin,
  input wire logic i_out_pin_oe,
  input wire logic i_rx_level,
  input wire logic i_meas_clr,
  output logic o_infrared_in_pin,
  output logic [31:0] o_lit_cycles,
  output logic [31:0] o_rise_count
);
  logic lit;
  logic lit_r;
  // the emitter only lights while the pin is actively driven high
  assign lit = i_out_pin & i_out_pin_oe;
  // the receiver output is a push-pull level, always driven
  assign o_infrared_in_pin = i_rx_level;
  // light statistics over a measurement window, cleared by the bench
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      lit_r <= 1'b0;
      o_lit_cycles <= 32'h0000_0000;
      o_rise_count <= 32'h0000_0000;
    end
    else
    begin
      lit_r <= lit;
      o_lit_cycles <= i_meas_clr ? 32'h0000_0000 : o_lit_cycles + 32'(lit);
      o_rise_count <= i_meas_clr ? 32'h0000_0000 : o_rise_count + 32'(lit & !lit_r);
    end
  end
endmodule : ircmt_ir_model
`default_nettype wire

// ---- verif/ircmt_top_bench.sv ----
// self-checking bench: register accesses and pin measurements of the ir timer
`timescale 1ns/10ps
`default_nettype none
`include "ircmt_params.svh"
module ircmt_top_bench;
  logic i_clk_sys, i_rst_b, rd_req, wr_req, rx_level, meas_clr;
  logic [2:0] addr;
  logic [31:0] wdata, rdata, readdata, lit_cycles, rise_count, m;
  logic [3:0] be;
  logic waitreq, irq, out_pin, out_oe, in_pin;
  int errors, n_tests;

  ircmt_top u_ircmt_top (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_avs_address(addr),
    .i_avs_read(rd_req), .i_avs_write(wr_req), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(readdata), .o_avs_waitrequest(waitreq), .o_irq(irq),
    .i_infrared_in_pin(in_pin), .o_infrared_out_pin(out_pin), .o_infrared_out_pin_oe(out_oe));
  ircmt_ir_model u_ircmt_ir_model (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_out_pin(out_pin),
    .i_out_pin_oe(out_oe), .i_rx_level(rx_level), .i_meas_clr(meas_clr), .o_infrared_in_pin(in_pin),
    .o_lit_cycles(lit_cycles), .o_rise_count(rise_count));

  // 250 MHz system clock
  initial
  begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // requests are held until waitrequest is sampled low; only the watchdog ends a hang
  task automatic bus_xfer(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    addr <= a;
    wdata <= d;
    wr_req <= w;
    rd_req <= !w;
    do
      @(posedge i_clk_sys);
    while (waitreq !== 1'b0);
    rdata = readdata;
    wr_req <= 1'b0;
    rd_req <= 1'b0;
  endtask : bus_xfer

  task automatic bus_write(input logic [2:0] a, input logic [31:0] d);
    bus_xfer(1'b1, a, d);
  endtask : bus_write

  task automatic bus_read(input logic [2:0] a);
    bus_xfer(1'b0, a, 32'h0000_0000);
  endtask : bus_read

  task automatic chk_eq(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_eq

  task automatic chk_range(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_tests++;
    if ((^got === 1'bx) || got < lo || got > hi)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask : chk_range

  task automatic cycles(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : cycles

  // clears the emitter statistics, then lets a window of 400 clocks pass
  task automatic measure();
    @(posedge i_clk_sys);
    meas_clr <= 1'b1;
    @(posedge i_clk_sys);
    meas_clr <= 1'b0;
    cycles(400);
  endtask : measure

  // overall hang guard, far beyond the few thousand clocks the tests need
  initial
  begin
    #200000;
    errors++;
    $display("CHECK FAILED t=%0t run did not finish", $time);
    final_report();
  end

  initial
  begin
    errors = 0;
    n_tests = 0;
    i_rst_b = 1'b0;
    rd_req = 1'b0;
    wr_req = 1'b0;
    addr = 3'h0;
    wdata = 32'h0000_0000;
    be = 4'hF;
    rx_level = 1'b0;
    meas_clr = 1'b0;
    cycles(5);
    i_rst_b <= 1'b1;
    // reset state: idle timer, pin undriven, no interrupt
    bus_read(`IRCMT_OFS_CTRL);
    chk_eq(rdata, 32'h0000_0000);
    bus_read(`IRCMT_OFS_STATUS);
    chk_eq({rdata[31:2], irq, out_oe}, 32'h0000_0000);
    bus_read(3'h7);
    chk_eq(rdata, 32'h0000_0000);
    // manual pin control while the timer is off
    bus_write(`IRCMT_OFS_POWER, 32'h0000_0003);
    cycles(3);
    chk_eq({out_pin, out_oe}, 32'h0000_0003);
    bus_write(`IRCMT_OFS_POWER, 32'h0000_0002);
    cycles(3);
    chk_eq({out_pin, out_oe}, 32'h0000_0001);
    bus_write(`IRCMT_OFS_POWER, 32'h0000_0000);
    // disabled counter must hold its value
    bus_write(`IRCMT_OFS_VALUE, 32'h0000_1234);
    cycles(40);
    bus_read(`IRCMT_OFS_VALUE);
    chk_eq(rdata, 32'h0000_1234);
    chk_eq({out_pin, out_oe}, 32'h0000_0000);
    // transmit: high 4, low 1 timer clocks, divider 1, fine clocking, data 1
    bus_write(`IRCMT_OFS_CARRIER, 32'h0000_0300);
    bus_write(`IRCMT_OFS_MODTIME, 32'h0000_0100);
    bus_write(`IRCMT_OFS_MASK, 32'h0000_0001);
    bus_write(`IRCMT_OFS_CTRL, 32'h0000_0487);
    bus_read(`IRCMT_OFS_VALUE);
    chk_range(rdata, 32'h0000_00F0, 32'h0000_0100);
    chk_eq({irq, out_oe}, 32'h0000_0001);
    measure();
    chk_range(lit_cycles, 32'd300, 32'd340);
    chk_range(rise_count, 32'd38, 32'd42);
    cycles(200);
    bus_read(`IRCMT_OFS_STATUS);
    chk_eq(rdata & 32'h0000_0001, 32'h0000_0001);
    chk_eq(32'(irq), 32'h0000_0001);
    // data 0 with polarity 1: constant idle high instead of carrier
    bus_write(`IRCMT_OFS_CTRL, 32'h0000_0000);
    bus_write(`IRCMT_OFS_CTRL, 32'h0000_040B);
    measure();
    chk_range(lit_cycles, 32'd395, 32'd400);
    chk_range(rise_count, 32'd0, 32'd1);
    // data 1, polarity 1, carrier clocking: inverted carrier lights 1 of every 5 clocks
    bus_write(`IRCMT_OFS_CTRL, 32'h0000_0000);
    bus_write(`IRCMT_OFS_MODTIME, 32'h0000_0003);
    bus_write(`IRCMT_OFS_CTRL, 32'h0000_000F);
    measure();
    chk_range(lit_cycles, 32'd75, 32'd85);
    chk_range(rise_count, 32'd78, 32'd82);
    bus_read(`IRCMT_OFS_VALUE);
    chk_range(rdata, 32'h0000_0000, 32'h0000_0003);
    bus_write(`IRCMT_OFS_CTRL, 32'h0000_0000);
    bus_write(`IRCMT_OFS_STATUS, 32'h0000_0003);
    bus_read(`IRCMT_OFS_STATUS);
    chk_eq(rdata, 32'h0000_0000);
    cycles(2);
    chk_eq(32'(irq), 32'h0000_0000);
    // receive counts up from the written value and wraps
    bus_write(`IRCMT_OFS_MASK, 32'h0000_0000);
    bus_write(`IRCMT_OFS_VALUE, 32'h0000_FFF0);
    bus_write(`IRCMT_OFS_CTRL, 32'h0000_0401);
    cycles(60);
    bus_read(`IRCMT_OFS_VALUE);
    chk_range(rdata, 32'h0000_0028, 32'h0000_0034);
    bus_read(`IRCMT_OFS_STATUS);
    chk_eq(rdata & 32'h0000_0002, 32'h0000_0002);
    chk_eq(32'(irq), 32'h0000_0000);
    bus_write(`IRCMT_OFS_MASK, 32'h0000_0002);
    cycles(2);
    chk_eq(32'(irq), 32'h0000_0001);
    bus_write(`IRCMT_OFS_CTRL, 32'h0000_0000);
    cycles(20);
    bus_read(`IRCMT_OFS_STATUS);
    chk_eq(rdata & 32'h0000_0002, 32'h0000_0002);
    bus_write(`IRCMT_OFS_STATUS, 32'h0000_0003);
    bus_write(`IRCMT_OFS_MASK, 32'h0000_0000);
    // capture on rising edge with clear-on-capture
    bus_write(`IRCMT_OFS_VALUE, 32'h0000_0000);
    bus_write(`IRCMT_OFS_CTRL, 32'h0000_0431);
    cycles(60);
    rx_level <= 1'b1;
    cycles(20);
    bus_read(`IRCMT_OFS_MODTIME);
    chk_range(rdata, 32'd55, 32'd80);
    bus_read(`IRCMT_OFS_CTRL);
    chk_eq(rdata & 32'h0000_0004, 32'h0000_0004);
    bus_read(`IRCMT_OFS_VALUE);
    chk_range(rdata, 32'd10, 32'd30);
    // free running through a falling-edge capture on both-edge select
    bus_write(`IRCMT_OFS_CTRL, 32'h0000_0441);
    cycles(30);
    rx_level <= 1'b0;
    cycles(20);
    bus_read(`IRCMT_OFS_MODTIME);
    m = rdata;
    chk_range(m, 32'd60, 32'd120);
    bus_read(`IRCMT_OFS_VALUE);
    chk_range(rdata, m, m + 32'd40);
    bus_read(`IRCMT_OFS_CTRL);
    chk_eq(rdata & 32'h0000_0004, 32'h0000_0000);
    final_report();
  end
endmodule : ircmt_top_bench
`default_nettype wire
